/* File: rtl/i2c_port_regs.vh */
`ifndef I2C_PORT_REGS_VH
`define I2C_PORT_REGS_VH
// target address, bits 7..1 of the address byte; bit 6 comes from the select pin
`define TGT_ADDR_HI         1'b0
`define TGT_ADDR_MID        4'b1111
`define TGT_ADDR_LO         1'b0
`define PTR_RESET           8'h00
`define SCL_MAX_KHZ         400
`define MCLK_KHZ            25000
// least mclk periods per scl period at the fastest legal bus rate
`define SCL_MIN_CYCLES      (`MCLK_KHZ / `SCL_MAX_KHZ)
`endif

/* File: rtl/sync2.v */
`timescale 1ns/1ns
module sync2 (
  input  wire mclk,
  input  wire rstn,
  input  wire d,
  output reg  q
);
  reg meta;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b1;
      q    <= 1'b1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* File: rtl/i2c_register_port.v */
// Behaviour
// - the port works with bus clocks up to 400 kHz and the controller must not go faster.
// - the port answers address byte 0,select pin,1111,0,direction.
// - a register read starts with a one-byte write whose byte becomes the register pointer.
// - the read then returns exactly one byte from the pointed register and ends with STOP.
// - a register write is address byte, pointer byte, then one data byte, stored into the pointed register.
`timescale 1ns/1ns
`include "i2c_port_regs.vh"
module i2c_register_port (
  input  wire       mclk,
  input  wire       rstn,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire       addr_select_or_connect_detect_pin,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  input  wire [7:0] reg_rdata,
  output reg        reg_rd,
  output reg        busy
);
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_ADDR = 6'b000010;
  localparam [5:0] S_PTR  = 6'b000100;
  localparam [5:0] S_WDAT = 6'b001000;
  localparam [5:0] S_RDAT = 6'b010000;
  localparam [5:0] S_SKIP = 6'b100000;

  // 400 kHz gives 62 mclk per scl period; three-cycle sampling delay fits easily
  localparam integer SCL_MIN = `SCL_MIN_CYCLES;

  wire scl_s;
  wire sda_s;
  wire sel_s;
  sync2 u_scl (.mclk(mclk), .rstn(rstn), .d(scl_in), .q(scl_s));
  sync2 u_sda (.mclk(mclk), .rstn(rstn), .d(sda_in), .q(sda_s));
  sync2 u_sel (.mclk(mclk), .rstn(rstn), .d(addr_select_or_connect_detect_pin), .q(sel_s));

  reg       scl_d;
  reg       sda_d;
  reg [5:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg       ack_phase;
  reg       drive_low;
  reg       rd_dir;
  reg       mstr_nack;

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  wire [6:0] own_addr = {`TGT_ADDR_HI, sel_s, `TGT_ADDR_MID, `TGT_ADDR_LO};

  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  reg [5:0] next_state;
  reg [3:0] next_bitcnt;
  reg [7:0] next_shreg;
  reg       next_ack_phase;
  reg       next_drive_low;
  reg       next_rd_dir;
  reg       next_mstr_nack;
  reg [7:0] next_reg_addr;
  reg [7:0] next_reg_wdata;
  reg       next_reg_wr;
  reg       next_reg_rd;
  reg       next_busy;

  // one extra stage after the synchronisers, only for edge and start/stop detection
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  always @* begin
    next_state     = state;
    next_bitcnt    = bitcnt;
    next_shreg     = shreg;
    next_ack_phase = ack_phase;
    next_drive_low = drive_low;
    next_rd_dir    = rd_dir;
    next_mstr_nack = mstr_nack;
    next_reg_addr  = reg_addr;
    next_reg_wdata = reg_wdata;
    next_reg_wr    = 1'b0;
    next_reg_rd    = 1'b0;
    next_busy      = busy;
    // start wins over everything: a repeated start aborts any byte in flight
    if (start_c) begin
      next_state     = S_ADDR;
      next_bitcnt    = 4'h0;
      next_ack_phase = 1'b0;
      next_drive_low = 1'b0;
      next_busy      = 1'b1;
    end else if (stop_c) begin
      next_state     = S_IDLE;
      next_drive_low = 1'b0;
      next_busy      = 1'b0;
    end else if (state != S_IDLE && state != S_SKIP) begin
      if (scl_rise && !ack_phase) begin
        if (state != S_RDAT) begin
          next_shreg = {shreg[6:0], sda_s};
        end
        next_bitcnt = bitcnt + 4'h1;
      end else if (scl_rise && ack_phase && state == S_RDAT) begin
        next_mstr_nack = sda_s;
      end else if (scl_fall) begin
        // sda only moves after scl falls, so hold time is the sync latency
        if (!ack_phase && bitcnt == 4'h8) begin
          next_ack_phase = 1'b1;
          next_bitcnt    = 4'h0;
          case (state)
            S_ADDR: begin
              if (shreg[7:1] == own_addr) begin
                next_drive_low = 1'b1;
                next_rd_dir    = shreg[0];
                if (shreg[0]) begin
                  next_reg_rd = 1'b1;
                end
              end else begin
                next_state = S_SKIP;
              end
            end
            S_PTR: begin
              next_reg_addr  = shreg;
              next_drive_low = 1'b1;
            end
            S_WDAT: begin
              next_reg_wdata = shreg;
              next_reg_wr    = 1'b1;
              next_drive_low = 1'b1;
            end
            S_RDAT: begin
              next_drive_low = 1'b0;
            end
            default: begin
              next_drive_low = 1'b0;
            end
          endcase
        end else if (ack_phase) begin
          next_ack_phase = 1'b0;
          next_drive_low = 1'b0;
          case (state)
            S_ADDR: begin
              if (rd_dir) begin
                // read data sampled here, one scl period (the ack bit) after the read pulse
                next_state     = S_RDAT;
                next_shreg     = {reg_rdata[6:0], 1'b0};
                next_drive_low = ~reg_rdata[7];
                next_bitcnt    = 4'h0;
              end else begin
                next_state = S_PTR;
              end
            end
            S_PTR:   next_state = S_WDAT;
            // extra bytes get no ack: no auto-increment
            S_WDAT:  next_state = S_SKIP;
            S_RDAT:  next_state = S_SKIP;
            default: next_state = S_SKIP;
          endcase
        end else if (state == S_RDAT) begin
          next_drive_low = ~shreg[7];
          next_shreg     = {shreg[6:0], 1'b0};
        end
      end
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state     <= S_IDLE;
      bitcnt    <= 4'h0;
      shreg     <= 8'h00;
      ack_phase <= 1'b0;
      rd_dir    <= 1'b0;
      mstr_nack <= 1'b0;
    end else begin
      state     <= next_state;
      bitcnt    <= next_bitcnt;
      shreg     <= next_shreg;
      ack_phase <= next_ack_phase;
      rd_dir    <= next_rd_dir;
      mstr_nack <= next_mstr_nack;
    end
  end

  // pin driver kept in its own flop so sda never glitches low
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      drive_low <= 1'b0;
    end else begin
      drive_low <= next_drive_low;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_addr  <= `PTR_RESET;
      reg_wdata <= 8'h00;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      busy      <= 1'b0;
    end else begin
      reg_addr  <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      reg_wr    <= next_reg_wr;
      reg_rd    <= next_reg_rd;
      busy      <= next_busy;
    end
  end
endmodule

/* File: verification/i2c_register_port_chk.sv */
`timescale 1ns/1ns
module i2c_register_port_chk (
  input wire       mclk,
  input wire       rstn,
  input wire       sda_oe,
  input wire       sda_out,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire       busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_rd_pulse;
    busy ##1 !reg_rd;
  endsequence
  property p_wr; reg_wr |=> !reg_wr; endproperty
  property p_wr_busy; reg_wr |-> busy && !reg_rd; endproperty
  property p_rd; reg_rd |-> s_rd_pulse; endproperty
  property p_ptr; !$stable(reg_addr) |-> $past(busy); endproperty
  property p_idle; !busy |-> !sda_oe; endproperty
  property p_od; sda_oe |-> sda_out == 1'b0; endproperty
  a_wr: assert property (p_wr) else $error("wr pulse");
  a_wr_busy: assert property (p_wr_busy) else $error("wr busy");
  a_rd: assert property (p_rd) else $error("rd pulse");
  a_ptr: assert property (p_ptr) else $error("ptr");
  a_idle: assert property (p_idle) else $error("idle");
  a_od: assert property (p_od) else $error("od");
endmodule
bind i2c_register_port i2c_register_port_chk i_chk (.mclk(mclk), .rstn(rstn),
  .sda_oe(sda_oe), .sda_out(sda_out), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .busy(busy));

/* File: verification/i2c_ctrl_model.sv */
`timescale 1ns/1ns
module i2c_ctrl_model (
  input  wire sda,
  output reg  scl,
  output reg  pull
);
  initial begin
    scl = 1;
    pull = 0;
  end
  task start;
    begin
      #80 pull = 0;
      #80 scl = 1;
      #80 pull = 1;
      #80 scl = 0;
    end
  endtask
  task stop;
    begin
      #80 pull = 1;
      #80 scl = 1;
      #80 pull = 0;
    end
  endtask
  // msb first, ninth bit is the ack slot
  task xfer(input [8:0] d, output [8:0] q);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      #80 pull = !d[i];
      #80 scl = 1;
      #80 q[i] = sda;
      #80 scl = 0;
    end
  endtask
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ns
module testbench;
  reg        mclk, rstn, sel;
  reg  [7:0] wa, wd;
  reg  [8:0] q;
  integer    num_errors, n_compared, n_wr;
  wire [7:0] reg_addr, reg_wdata;
  wire       scl, pull, sda_oe, reg_wr, reg_rd, busy;
  wire       sda = !(pull | sda_oe);
  i2c_register_port i_i2c_register_port (.mclk(mclk), .rstn(rstn), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .addr_select_or_connect_detect_pin(sel),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(~reg_addr), .reg_rd(reg_rd), .busy(busy));
  i2c_ctrl_model m (.sda(sda), .scl(scl), .pull(pull));
  initial begin
    mclk = 0;
    forever #20 mclk = !mclk;
  end
  always @(posedge mclk) if (reg_wr) begin
    n_wr <= n_wr + 1;
    wa   <= reg_addr;
    wd   <= reg_wdata;
  end
  task chk(input [31:0] nm, input [7:0] e, input [7:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wb(input [7:0] b, input e);
    begin
      m.xfer({b, 1'b1}, q);
      chk("ack", {7'h0, e}, {7'h0, q[0]});
    end
  endtask
  task conclude;
    begin
      $display("errors %0d compares %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task t_write;
    begin
      m.start;
      wb(8'h7c, 0);
      wb(8'h19, 0);
      wb(8'ha5, 0);
      wb(8'h5a, 1);
      m.stop;
      chk("wrn", 1, n_wr[7:0]);
      chk("wra", 8'h19, wa);
      chk("wrd", 8'ha5, wd);
    end
  endtask
  task t_read;
    begin
      m.start;
      wb(8'h7c, 0);
      wb(8'h3c, 0);
      m.start;
      wb(8'h7d, 0);
      m.xfer(9'h1ff, q);
      m.stop;
      chk("rdat", 8'hc3, q[8:1]);
      @(posedge mclk);
      #1 sel = 0;
      #400;
    end
  endtask
  task t_wrong;
    begin
      m.start;
      wb(8'h7c, 1);
      wb(8'h55, 1);
      m.stop;
      chk("ptr", 8'h3c, reg_addr);
      m.start;
      wb(8'h3c, 0);
      wb(8'h01, 0);
      m.stop;
      chk("ptr", 8'h01, reg_addr);
      chk("wrn", 1, n_wr[7:0]);
    end
  endtask
  initial begin
    rstn = 0;
    sel = 1;
    num_errors = 0;
    n_compared = 0;
    n_wr = 0;
    repeat (10) @(posedge mclk);
    #1 rstn = 1;
    repeat (4) @(posedge mclk);
    #1;
    t_write;
    t_read;
    t_wrong;
    conclude;
  end
  initial begin
    #200000;
    num_errors = num_errors + 1;
    conclude;
  end
endmodule
